// ==== rtl/rx_buffer_if.sv ====
// Handshake bundle between the receiver and its two-entry buffer.
`timescale 1ns/1ps
`default_nettype none
interface rx_buffer_if;
  logic push_valid;
  logic push_ready;
  logic [7:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [7:0] pop_data;
  logic flush;
  modport src (output push_valid, push_data, pop_ready, flush,
               input push_ready, pop_valid, pop_data);
  modport buf_side (input push_valid, push_data, pop_ready, flush,
                    output push_ready, pop_valid, pop_data);
endinterface : rx_buffer_if
`default_nettype wire

// ==== rtl/serial_port_pkg.sv ====
// Shared constants, types and helpers of the serial port block.
package serial_port_pkg;

  // ---------------------------------------------------------------
  // I/O port addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] DATA_PORT = 8'h12;
  localparam logic [7:0] CTL_PORT = 8'h13;
  localparam logic [7:0] DATA_ALIAS = 8'h04;
  localparam logic [7:0] CTL_ALIAS = 8'h05;
  localparam logic [7:0] DATA_CONSOLE = 8'h02;
  localparam logic [7:0] CTL_CONSOLE = 8'h03;

  // ---------------------------------------------------------------
  // Format byte fields and reset values
  // ---------------------------------------------------------------
  localparam int BAUD_FACTOR_LSB = 0;
  localparam int CHAR_LEN_LSB = 2;
  localparam int PARITY_ON_BIT = 4;
  localparam int PARITY_SENSE_BIT = 5;
  localparam int STOP_COUNT_LSB = 6;
  localparam int SINGLE_SYNC_BIT = 7;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam logic [1:0] FACTOR_SYNC = 2'h0;
  localparam logic [1:0] FACTOR_X1 = 2'h1;
  localparam logic [1:0] FACTOR_X16 = 2'h2;
  localparam logic [1:0] FACTOR_X64 = 2'h3;
  localparam logic [6:0] TICKS_X1 = 7'h01;
  localparam logic [6:0] TICKS_X16 = 7'h10;
  localparam logic [6:0] TICKS_X64 = 7'h40;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_ONE_HALF = 2'h2;

  // ---------------------------------------------------------------
  // Command bits
  // ---------------------------------------------------------------
  localparam int CMD_TX_ENABLE = 0;
  localparam int CMD_DTR = 1;
  localparam int CMD_RX_ENABLE = 2;
  localparam int CMD_BREAK = 3;
  localparam int CMD_ERR_RESET = 4;
  localparam int CMD_RTS = 5;
  localparam int CMD_INT_RESET = 6;

  // ---------------------------------------------------------------
  // Decode results and state types
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_CTL = 2'h2;

  typedef enum logic [1:0] {
    CTL_EXPECT_MODE, CTL_EXPECT_SYNC1, CTL_EXPECT_SYNC2, CTL_COMMAND
  } ctl_state_t;

  typedef enum logic [2:0] {
    LINE_IDLE, LINE_START, LINE_DATA, LINE_PARITY, LINE_STOP
  } line_state_t;

  function automatic logic [1:0] port_sel(input logic [7:0] addr,
                                          input logic alias_on);
    if (addr == DATA_PORT || addr == DATA_ALIAS) begin
      port_sel = SEL_DATA;
    end else if (addr == CTL_PORT || addr == CTL_ALIAS) begin
      port_sel = SEL_CTL;
    end else if (alias_on && addr == DATA_CONSOLE) begin
      port_sel = SEL_DATA;
    end else if (alias_on && addr == CTL_CONSOLE) begin
      port_sel = SEL_CTL;
    end else begin
      port_sel = SEL_NONE;
    end
  endfunction : port_sel

  function automatic logic [6:0] ticks_per_bit(input logic [1:0] factor);
    case (factor)
      FACTOR_X16: ticks_per_bit = TICKS_X16;
      FACTOR_X64: ticks_per_bit = TICKS_X64;
      default: ticks_per_bit = TICKS_X1;
    endcase
  endfunction : ticks_per_bit

  function automatic logic [7:0] char_mask(input logic [1:0] len);
    char_mask = 8'hFF >> (2'h3 - len);
  endfunction : char_mask

endpackage : serial_port_pkg

// ==== rtl/serial_port_setup.sv ====
// Serial port: I/O decode, format and command handling, transmitter, receiver.
//
// Overview of operation
// RULE_01: Current loop only in asynchronous timing.
// RULE_02: Async switch on: receiver uses baud generator. The code gives the receiver no clock if the sync switch is also on.
// RULE_03: Sync switch on: receiver uses external clock. The code gives the receiver no clock if the async switch is also on.
// RULE_04: Transmitter always uses baud generator.
// RULE_05: Loop drive off in synchronous configuration.
// RULE_06: Software writes format byte after reset.
// RULE_07: First control write after reset is format.
// RULE_08: Control write and status read share address.
// RULE_09: Software resets with three zeros, then 40.
// RULE_10: Command 40 resets; next write is format.
// RULE_11: Ports at 12/13, 04/05, optional 02/03.
// RULE_12: Format bits 1:0 select baud factor.
// RULE_13: Format bits 3:2 select five to eight bits.
// RULE_14: Carrier detect driven true at computer end.
// RULE_15: Async needs data lines; sync adds clocks.
// RULE_16: Format bit 4 enables parity.
// RULE_17: Format bit 5: zero odd, one even.
// RULE_18: Format bits 7:6 select stop length.
`timescale 1ns/1ps
`default_nettype none
module serial_port_setup
  import serial_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Processor I/O port access
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rd_hit,
  // Option switches and end configuration
  input wire logic loop_mode_switch,
  input wire logic async_timing_switch,
  input wire logic sync_timing_switch,
  input wire logic console_serial_alias_switch,
  input wire logic computer_end,
  // Board baud generator, one-cycle tick
  input wire logic baud_tick,
  // Line pins
  input wire logic rxd,
  input wire logic rxc,
  input wire logic loop_rx,
  input wire logic cts,
  input wire logic dsr,
  output logic txd,
  output logic loop_tx,
  output logic rts,
  output logic dtr,
  output logic carrier_detect
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [8:0] pin_meta;
  logic [8:0] pin_sync;
  logic rxc_prev;
  always_ff @(posedge clk) begin
    pin_meta <= {loop_mode_switch, async_timing_switch, sync_timing_switch,
                 console_serial_alias_switch, computer_end, rxd, rxc,
                 loop_rx, cts};
    pin_sync <= pin_meta;
    rxc_prev <= pin_sync[2];
  end
  logic dsr_meta;
  logic dsr_sync;
  always_ff @(posedge clk) begin
    dsr_meta <= dsr;
    dsr_sync <= dsr_meta;
  end
  logic loop_sw, async_sw, sync_sw, alias_sw, comp_end, rxd_s, loop_rx_s;
  logic cts_s;
  assign {loop_sw, async_sw, sync_sw, alias_sw, comp_end, rxd_s} =
    pin_sync[8:3];
  assign loop_rx_s = pin_sync[1];
  assign cts_s = pin_sync[0];

  // ---------------------------------------------------------------
  // Format and command handling
  // ---------------------------------------------------------------
  ctl_state_t ctl_state;
  logic [7:0] serial_format_setting;
  logic [7:0] command;
  logic [1:0] wsel;
  logic ctl_wr, data_wr, soft_rst;
  assign wsel = port_sel(io_addr, alias_sw); // see RULE_11
  assign ctl_wr = io_wr && wsel == SEL_CTL; // see RULE_08
  assign data_wr = io_wr && wsel == SEL_DATA;
  assign soft_rst = ctl_wr && ctl_state == CTL_COMMAND &&
                    io_wdata[CMD_INT_RESET]; // see RULE_10

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_state <= CTL_EXPECT_MODE;
      serial_format_setting <= FORMAT_RESET;
      command <= COMMAND_RESET;
    end else if (ctl_wr) begin
      case (ctl_state)
        CTL_EXPECT_MODE: begin
          serial_format_setting <= io_wdata; // see RULE_07
          ctl_state <= (io_wdata[1:0] == FACTOR_SYNC) ?
                       CTL_EXPECT_SYNC1 : CTL_COMMAND;
        end
        CTL_EXPECT_SYNC1: begin
          ctl_state <= serial_format_setting[SINGLE_SYNC_BIT] ?
                       CTL_COMMAND : CTL_EXPECT_SYNC2;
        end
        CTL_EXPECT_SYNC2: begin
          ctl_state <= CTL_COMMAND;
        end
        default: begin
          if (io_wdata[CMD_INT_RESET]) begin
            ctl_state <= CTL_EXPECT_MODE; // see RULE_10
            command <= COMMAND_RESET;
          end else begin
            command <= io_wdata;
          end
        end
      endcase
    end
  end

  logic [1:0] factor, char_len, stop_sel;
  logic parity_on, parity_sense, sync_mode;
  logic [6:0] bit_ticks;
  logic [2:0] last_bit;
  logic [7:0] stop_ticks;
  assign factor = serial_format_setting[BAUD_FACTOR_LSB +: 2];
  assign char_len = serial_format_setting[CHAR_LEN_LSB +: 2];
  assign parity_on = serial_format_setting[PARITY_ON_BIT]; // see RULE_16
  assign parity_sense = serial_format_setting[PARITY_SENSE_BIT];
  assign stop_sel = serial_format_setting[STOP_COUNT_LSB +: 2];
  assign sync_mode = (factor == FACTOR_SYNC);
  assign bit_ticks = sync_mode ? TICKS_X1 : ticks_per_bit(factor); // see RULE_12
  assign last_bit = {1'b1, char_len} - 3'h4 + 3'h4; // see RULE_13
  // A 1x factor cannot split a bit, so one and a half stop bits become two.
  always_comb begin
    if (stop_sel == STOP_ONE) begin
      stop_ticks = {1'b0, bit_ticks}; // see RULE_18
    end else if (stop_sel == STOP_ONE_HALF && factor != FACTOR_X1) begin
      stop_ticks = {1'b0, bit_ticks} + {2'b00, bit_ticks[6:1]};
    end else begin
      stop_ticks = {bit_ticks, 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Clock selection and loop drive
  // ---------------------------------------------------------------
  logic rx_tick, loop_en, line_in;
  always_comb begin
    if (async_sw && !sync_sw) begin
      rx_tick = baud_tick; // see RULE_02
    end else if (sync_sw && !async_sw) begin
      rx_tick = pin_sync[2] && !rxc_prev; // see RULE_03
    end else begin
      rx_tick = 1'b0;
    end
  end
  // see RULE_01, see RULE_05
  assign loop_en = loop_sw && async_sw && !sync_sw && !sync_mode;
  assign line_in = loop_en ? loop_rx_s : rxd_s; // see RULE_15

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  line_state_t tx_state;
  logic [7:0] tx_hold, tx_shift, tx_cnt;
  logic tx_full, tx_line, tx_load, tx_adv, tx_par;
  logic [2:0] tx_bit;
  assign tx_load = tx_state == LINE_IDLE && tx_full &&
                   command[CMD_TX_ENABLE] && cts_s;
  assign tx_adv = baud_tick && (tx_cnt == ((tx_state == LINE_STOP) ?
                  stop_ticks : {1'b0, bit_ticks}) - 8'h01); // see RULE_04

  always_ff @(posedge clk) begin
    if (sys_rst || soft_rst) begin
      tx_full <= 1'b0;
    end else if (data_wr) begin
      tx_full <= 1'b1;
      tx_hold <= io_wdata;
    end else if (tx_load) begin
      tx_full <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || soft_rst) begin
      tx_state <= LINE_IDLE;
      tx_line <= 1'b1;
      tx_cnt <= 8'h00;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      tx_par <= 1'b0;
    end else if (tx_load) begin
      tx_shift <= tx_hold & char_mask(char_len);
      tx_par <= ^(tx_hold & char_mask(char_len)) ^ ~parity_sense; // see RULE_17
      tx_cnt <= 8'h00;
      tx_bit <= 3'h0;
      tx_state <= sync_mode ? LINE_DATA : LINE_START;
      tx_line <= sync_mode ? tx_hold[0] : 1'b0;
    end else if (baud_tick && tx_state != LINE_IDLE) begin
      tx_cnt <= tx_adv ? 8'h00 : tx_cnt + 8'h01;
      if (tx_adv) begin
        case (tx_state)
          LINE_START: begin
            tx_state <= LINE_DATA;
            tx_line <= tx_shift[0];
          end
          LINE_DATA: begin
            tx_bit <= tx_bit + 3'h1;
            tx_line <= tx_shift[tx_bit + 3'h1];
            if (tx_bit == last_bit) begin
              tx_state <= parity_on ? LINE_PARITY :
                          (sync_mode ? LINE_IDLE : LINE_STOP);
              tx_line <= parity_on ? tx_par : 1'b1;
            end
          end
          LINE_PARITY: begin
            tx_state <= sync_mode ? LINE_IDLE : LINE_STOP;
            tx_line <= 1'b1;
          end
          default: begin
            tx_state <= LINE_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  rx_buffer_if rxb ();
  two_entry_buffer u_buffer (.clk(clk), .sys_rst(sys_rst), .bus(rxb));

  line_state_t rx_state;
  logic [7:0] rx_shift, rx_cnt;
  logic [2:0] rx_bit;
  logic rx_adv, rx_done, rx_pe_now, parity_err, overrun, framing;
  assign rx_adv = rx_tick && rx_cnt == ((rx_state == LINE_START) ?
                  {2'b00, bit_ticks[6:1]} : {1'b0, bit_ticks} - 8'h01);
  assign rx_done = rx_adv && ((rx_state == LINE_STOP) ||
                   (sync_mode && ((rx_state == LINE_PARITY) ||
                   (rx_state == LINE_DATA && rx_bit == last_bit &&
                    !parity_on))));
  assign rx_pe_now = rx_adv && rx_state == LINE_PARITY &&
                     (line_in != (^rx_shift ^ ~parity_sense));
  assign rxb.push_valid = rx_done && command[CMD_RX_ENABLE];
  assign rxb.push_data = rx_shift & char_mask(char_len);
  assign rxb.flush = soft_rst;

  always_ff @(posedge clk) begin
    if (sys_rst || soft_rst || !command[CMD_RX_ENABLE]) begin
      rx_state <= LINE_IDLE;
      rx_cnt <= 8'h00;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
    end else if (rx_state == LINE_IDLE) begin
      if (sync_mode || (rx_tick && !line_in)) begin
        rx_state <= sync_mode ? LINE_DATA : LINE_START;
        rx_cnt <= 8'h00;
        rx_bit <= 3'h0;
        rx_shift <= 8'h00;
      end
    end else if (rx_tick) begin
      rx_cnt <= rx_adv ? 8'h00 : rx_cnt + 8'h01;
      if (rx_adv) begin
        case (rx_state)
          LINE_START: begin
            rx_state <= line_in ? LINE_IDLE : LINE_DATA;
          end
          LINE_DATA: begin
            rx_shift[rx_bit] <= line_in;
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == last_bit) begin
              rx_state <= parity_on ? LINE_PARITY :
                          (sync_mode ? LINE_IDLE : LINE_STOP);
            end
          end
          LINE_PARITY: begin
            rx_state <= sync_mode ? LINE_IDLE : LINE_STOP;
          end
          default: begin
            rx_state <= LINE_IDLE;
          end
        endcase
      end
    end
  end

  // A new error wins over an error reset arriving in the same cycle.
  logic err_clr;
  assign err_clr = ctl_wr && ctl_state == CTL_COMMAND &&
                   io_wdata[CMD_ERR_RESET];
  always_ff @(posedge clk) begin
    if (sys_rst || soft_rst) begin
      parity_err <= 1'b0;
      overrun <= 1'b0;
      framing <= 1'b0;
    end else begin
      parity_err <= (parity_err && !err_clr) || rx_pe_now;
      overrun <= (overrun && !err_clr) ||
                 (rxb.push_valid && !rxb.push_ready);
      framing <= (framing && !err_clr) ||
                 (rx_adv && rx_state == LINE_STOP && !line_in);
    end
  end

  // ---------------------------------------------------------------
  // Read path and pin outputs
  // ---------------------------------------------------------------
  logic [7:0] status;
  logic [1:0] rsel;
  assign rsel = port_sel(io_addr, alias_sw); // see RULE_11
  assign status = {dsr_sync, 1'b0, framing, overrun, parity_err,
                   !tx_full && tx_state == LINE_IDLE, rxb.pop_valid,
                   !tx_full && command[CMD_TX_ENABLE]};
  assign rxb.pop_ready = io_rd && rsel == SEL_DATA;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
      io_rd_hit <= 1'b0;
      txd <= 1'b1;
      loop_tx <= 1'b0;
      carrier_detect <= 1'b0;
      rts <= 1'b0;
      dtr <= 1'b0;
    end else begin
      io_rd_hit <= io_rd && rsel != SEL_NONE;
      if (io_rd && rsel == SEL_CTL) begin
        io_rdata <= status; // see RULE_08
      end else if (io_rd && rsel == SEL_DATA) begin
        io_rdata <= rxb.pop_data;
      end else begin
        io_rdata <= 8'h00;
      end
      txd <= tx_line && !command[CMD_BREAK];
      loop_tx <= loop_en && tx_line && !command[CMD_BREAK]; // see RULE_01
      carrier_detect <= comp_end; // see RULE_14
      rts <= command[CMD_RTS];
      dtr <= command[CMD_DTR];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_format_write;
    ctl_wr && ctl_state == CTL_EXPECT_MODE;
  endsequence
  property p_format_first;
    @(posedge clk) disable iff (sys_rst)
    s_format_write |=> serial_format_setting == $past(io_wdata) &&
                       ctl_state != CTL_EXPECT_MODE;
  endproperty
  a_format_first: assert property (p_format_first) // see RULE_07
    else $error("first control write not taken as format");

  sequence s_reset_cmd;
    soft_rst;
  endsequence
  property p_reset_cmd;
    @(posedge clk) disable iff (sys_rst)
    s_reset_cmd |=> ctl_state == CTL_EXPECT_MODE && command == COMMAND_RESET
                    && tx_state == LINE_IDLE;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) // see RULE_10
    else $error("reset command did not return to format state");

  property p_status_read;
    @(posedge clk) disable iff (sys_rst)
    io_rd && rsel == SEL_CTL |=> io_rdata == $past(status) && io_rd_hit;
  endproperty
  a_status_read: assert property (p_status_read) // see RULE_08
    else $error("status read returned wrong value");

  property p_alias_off;
    @(posedge clk) disable iff (sys_rst)
    io_rd && !alias_sw && (io_addr == CTL_CONSOLE || io_addr == DATA_CONSOLE)
    |=> !io_rd_hit;
  endproperty
  a_alias_off: assert property (p_alias_off) // see RULE_11
    else $error("console alias answered while switched off");

  property p_tx_clock;
    @(posedge clk) disable iff (sys_rst || soft_rst)
    tx_state != LINE_IDLE && $past(tx_state) != LINE_IDLE && $changed(tx_cnt)
    |-> $past(baud_tick);
  endproperty
  a_tx_clock: assert property (p_tx_clock) // see RULE_04
    else $error("transmitter advanced without baud tick");

  property p_rx_clock;
    @(posedge clk) disable iff (sys_rst)
    $changed(rx_cnt) && rx_cnt != 8'h00 |-> $past(rx_tick) &&
      ($past(async_sw) != $past(sync_sw));
  endproperty
  a_rx_clock: assert property (p_rx_clock) // see RULE_02, see RULE_03
    else $error("receiver advanced without selected clock");

  property p_loop_sync;
    @(posedge clk) disable iff (sys_rst)
    loop_tx |-> $past(async_sw) && !$past(sync_sw) && !$past(sync_mode);
  endproperty
  a_loop_sync: assert property (p_loop_sync) // see RULE_05
    else $error("loop driven in synchronous configuration");

  property p_carrier;
    @(posedge clk) disable iff (sys_rst)
    comp_end [*3] |=> carrier_detect;
  endproperty
  a_carrier: assert property (p_carrier) // see RULE_14
    else $error("carrier detect not true at computer end");

  property p_char_len;
    @(posedge clk) disable iff (sys_rst)
    rxb.push_valid |-> (rx_shift & ~char_mask(char_len)) == 8'h00;
  endproperty
  a_char_len: assert property (p_char_len) // see RULE_13
    else $error("received character wider than format");
endmodule : serial_port_setup
`default_nettype wire

// ==== rtl/two_entry_buffer.sv ====
// Two-entry buffer holding received characters until software reads them.
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Buffer side of the handshake bundle
  rx_buffer_if.buf_side bus
);
  logic [7:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic do_push;
  logic do_pop;

  assign bus.push_ready = (count != 2'h2);
  assign bus.pop_valid = (count != 2'h0);
  assign bus.pop_data = mem[rd_ptr];
  assign do_push = bus.push_valid && bus.push_ready;
  assign do_pop = bus.pop_ready && bus.pop_valid;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= bus.push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || bus.flush) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      wr_ptr <= wr_ptr ^ do_push;
      rd_ptr <= rd_ptr ^ do_pop;
      count <= count + {1'b0, do_push} - {1'b0, do_pop};
    end
  end
endmodule : two_entry_buffer
`default_nettype wire

// ==== testbench/serial_port_setup_tb.sv ====
// Self-checking bench for the serial port block.
`timescale 1ns/1ps
`default_nettype none
module serial_port_setup_tb;
  import serial_port_pkg::*;
  // ------------------------------------------------------------
  // Signals, design and terminal
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic loop_mode_switch = 1'b0;
  logic async_timing_switch = 1'b1;
  logic sync_timing_switch = 1'b0;
  logic console_serial_alias_switch = 1'b0;
  logic computer_end = 1'b1;
  logic baud_tick = 1'b0;
  logic rxc = 1'b0;
  logic cts = 1'b1;
  logic dsr = 1'b1;
  wire logic [7:0] io_rdata;
  wire logic io_rd_hit, txd, rxd, loop_tx, rts, dtr, carrier_detect;
  logic [7:0] st;
  logic hit;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  always #50 clk = ~clk;
  // Baud generator and modem clock run free, one tick every second cycle.
  always @(posedge clk) begin
    #5;
    baud_tick = ~baud_tick;
    rxc = ~rxc;
  end
  serial_port_setup serial_port_setup_i (.clk(clk), .sys_rst(sys_rst),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rd_hit(io_rd_hit),
    .loop_mode_switch(loop_mode_switch),
    .async_timing_switch(async_timing_switch),
    .sync_timing_switch(sync_timing_switch),
    .console_serial_alias_switch(console_serial_alias_switch),
    .computer_end(computer_end), .baud_tick(baud_tick), .rxd(rxd),
    .rxc(rxc), .loop_rx(loop_tx), .cts(cts), .dsr(dsr), .txd(txd),
    .loop_tx(loop_tx), .rts(rts), .dtr(dtr),
    .carrier_detect(carrier_detect));
  serial_terminal #(.BIT(32)) serial_terminal_i (.clk(clk), .txd(txd),
    .rxd(rxd));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #5;
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    settle(1);
    io_wr = 1'b0;
    settle(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    io_addr = a;
    io_rd = 1'b1;
    settle(1);
    io_rd = 1'b0;
    st = io_rdata;
    hit = io_rd_hit;
    settle(1);
  endtask : rd
  // Polls status until a word is waiting; a bound keeps a hang short.
  task automatic wait_rx();
    st = 8'h00;
    for (int k = 0; k < 400 && st[1] !== 1'b1; k++) begin
      rd(CTL_PORT);
    end
    if (st[1] !== 1'b1) begin
      err_count++;
      summarize();
    end
  endtask : wait_rx
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    settle(20000);
    err_count++;
    summarize();
  end
  initial begin
    settle(3);
    sys_rst = 1'b0;
    settle(4);
    check("pins", {4'h0, txd, loop_tx, rts, dtr}, 8'h08);
    check("cd", {7'h00, carrier_detect}, 8'h01);
    wr(CTL_PORT, 8'h5E);
    wr(CTL_PORT, 8'h37);
    check("rts_dtr", {6'h00, rts, dtr}, 8'h03);
    rd(CTL_PORT);
    check("status", st & 8'h81, 8'h81);
    cts = 1'b0;
    settle(5);
    n = serial_terminal_i.frames;
    wr(DATA_PORT, 8'hA5);
    settle(10);
    rd(CTL_PORT);
    check("cts_hold", st & 8'h05, 8'h00);
    cts = 1'b1;
    for (int k = 0; k < 600 && serial_terminal_i.frames == n; k++) begin
      settle(1);
    end
    if (serial_terminal_i.frames == n) begin
      err_count++;
      summarize();
    end
    check("tx", serial_terminal_i.rx_byte, 8'hA5);
    check("par", {7'h00, serial_terminal_i.rx_par}, 8'h01);
    check("stop", {7'h00, serial_terminal_i.rx_stop}, 8'h01);
    // A third word with nobody reading must be dropped, not overwrite.
    serial_terminal_i.send(8'h11);
    serial_terminal_i.send(8'h22);
    serial_terminal_i.send(8'h33);
    settle(20);
    rd(CTL_PORT);
    check("ovr", st & 8'h12, 8'h12);
    rd(DATA_PORT);
    check("rx1", st, 8'h11);
    rd(DATA_ALIAS);
    check("rx2", st, 8'h22);
    rd(CTL_ALIAS);
    check("empty", st & 8'h02, 8'h00);
    wr(CTL_PORT, 8'h37);
    rd(CTL_PORT);
    check("ovr_clr", st & 8'h10, 8'h00);
    rd(CTL_CONSOLE);
    check("con_off", {7'h00, hit}, 8'h00);
    console_serial_alias_switch = 1'b1;
    dsr = 1'b0;
    settle(5);
    rd(CTL_CONSOLE);
    check("con_on", {hit, 6'h00, st[0]}, 8'h81);
    check("dsr", {7'h00, st[7]}, 8'h00);
    rd(8'h20);
    check("unmapped", st | {7'h00, hit}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wr(CTL_ALIAS, 8'h00);
    end
    wr(CTL_ALIAS, 8'h40);
    check("soft_rst", {7'h00, rts}, 8'h00);
    wr(CTL_PORT, 8'h5E);
    wr(CTL_PORT, 8'h37);
    check("re_fmt", {7'h00, rts}, 8'h01);
    loop_mode_switch = 1'b1;
    settle(5);
    check("loop_idle", {7'h00, loop_tx}, 8'h01);
    wr(DATA_PORT, 8'h5A);
    wait_rx();
    rd(DATA_PORT);
    check("loop_rx", st, 8'h5A);
    async_timing_switch = 1'b0;
    sync_timing_switch = 1'b1;
    computer_end = 1'b0;
    settle(5);
    check("loop_sync", {7'h00, loop_tx}, 8'h00);
    check("cd_term", {7'h00, carrier_detect}, 8'h00);
    serial_terminal_i.send(8'h3C);
    wait_rx();
    rd(DATA_PORT);
    check("rx_ext_clk", st, 8'h3C);
    summarize();
  end
endmodule : serial_port_setup_tb
`default_nettype wire

// ==== testbench/serial_terminal.sv ====
// Far-side terminal model: frames bytes onto rxd and captures txd frames.
`timescale 1ns/1ps
`default_nettype none
module serial_terminal #(parameter int BIT = 16) (
  // Clock
  input wire logic clk,
  // Data lines seen from the terminal
  input wire logic txd,
  output logic rxd
);
  // ------------------------------------------------------------
  // Capture and send
  // ------------------------------------------------------------
  logic [7:0] rx_byte;
  logic rx_par;
  logic rx_stop;
  int frames = 0;
  initial rxd = 1'b1;
  // Only the two data lines are used; the mark level is the idle one.
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      rx_byte[i] = txd;
    end
    repeat (BIT) @(posedge clk);
    rx_par = txd;
    repeat (BIT) @(posedge clk);
    rx_stop = txd;
    frames++;
  end
  // Odd parity and one stop bit, least significant bit first.
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd = f[i];
      repeat (BIT) @(posedge clk);
      #5;
    end
  endtask : send
endmodule : serial_terminal
`default_nettype wire
